/* File: hdl/mdf_map.svh */
`ifndef MDF_MAP_SVH
`define MDF_MAP_SVH

// stream widths and counts
`define MDF_IW     16
`define MDF_CW     18
`define MDF_TAPS   11
`define MDF_CTR    5
`define MDF_HALF   5
`define MDF_PW     35
`define MDF_OW     39
`define MDF_NCH    4
`define MDF_CHW    2
`define MDF_DEC    2
`define MDF_PHW    4
`define MDF_BAND   2
`define MDF_LANES  1

// coefficient banks and slave port
`define MDF_NBANK  2
`define MDF_BKW    1
`define MDF_AW     8
`define MDF_DW     32
`define MDF_BASE   8'h40
`define MDF_NCOEF  22

// reconfigurable channel map
`define MDF_NMODE  2
`define MDF_MDW    1
`define MDF_NSLOT  4
`define MDF_SLW    2
`define MDF_CMAP '{'{2'h0, 2'h0, 2'h0, 2'h0}, '{2'h0, 2'h1, 2'h2, 2'h3}}

// reset coefficient sets, bank 0 half-band shaped, bank 1 plain lowpass
`define MDF_COEF_INIT '{ \
  '{18'h0_0100, 18'h0_0000, 18'h0_0800, 18'h0_0000, 18'h0_2000, \
    18'h0_4000, 18'h0_2000, 18'h0_0000, 18'h0_0800, 18'h0_0000, \
    18'h0_0100}, \
  '{18'h0_0040, 18'h0_0200, 18'h0_0600, 18'h0_1000, 18'h0_1800, \
    18'h0_2000, 18'h0_1800, 18'h0_1000, 18'h0_0600, 18'h0_0200, \
    18'h0_0040}}

`endif

/* File: hdl/mdf_pkg.sv */
`include "mdf_map.svh"

package mdf_pkg;

  typedef logic signed [`MDF_IW-1:0]  mdf_sample_t;
  typedef logic signed [`MDF_CW-1:0]  mdf_coef_t;
  typedef logic signed [`MDF_PW-1:0]  mdf_prod_t;
  typedef logic signed [`MDF_OW-1:0]  mdf_acc_t;
  typedef logic [`MDF_CHW-1:0]        mdf_chan_t;
  typedef mdf_sample_t [`MDF_TAPS-1:0] mdf_win_t;
  typedef mdf_coef_t [`MDF_TAPS-1:0]   mdf_cset_t;

  typedef enum logic [1:0] {
    MDF_SYM_NONE,
    MDF_SYM_EVEN,
    MDF_SYM_ODD
  } mdf_sym_t;

  typedef enum logic [1:0] {
    MDF_ACC_RO,
    MDF_ACC_WO,
    MDF_ACC_RW,
    MDF_ACC_CONST
  } mdf_access_t;

  typedef struct packed {
    logic        valid;
    mdf_chan_t   chan;
    mdf_sample_t data;
  } mdf_in_beat_t;

  typedef struct packed {
    logic      valid;
    mdf_chan_t chan;
    mdf_acc_t  data;
  } mdf_out_beat_t;

  typedef struct packed {
    logic                wr;
    logic                rd;
    logic [`MDF_AW-1:0]  addr;
    logic [`MDF_DW-1:0]  wdata;
  } mdf_mm_req_t;

  typedef struct packed {
    logic                hit;
    logic [`MDF_BKW-1:0] bank;
    logic [3:0]          tap;
  } mdf_dec_t;

endpackage : mdf_pkg

/* File: hdl/mdf_coef_store.sv */
`timescale 1ns/1ps
`include "mdf_map.svh"

module mdf_coef_store #(
  parameter mdf_pkg::mdf_access_t ACCESS = mdf_pkg::MDF_ACC_RW
) (
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  input  wire mdf_pkg::mdf_mm_req_t mm_req,
  input  wire logic [`MDF_BKW-1:0]  bank_sel,
  output mdf_pkg::mdf_cset_t        cset,
  output logic [`MDF_DW-1:0]        rdata_q,
  output logic                      rvalid_q
);

  localparam mdf_pkg::mdf_coef_t INIT [`MDF_NBANK][`MDF_TAPS] =
    `MDF_COEF_INIT;
  localparam logic CAN_WR = (ACCESS == mdf_pkg::MDF_ACC_WO) ||
                            (ACCESS == mdf_pkg::MDF_ACC_RW);
  localparam logic CAN_RD = (ACCESS == mdf_pkg::MDF_ACC_RO) ||
                            (ACCESS == mdf_pkg::MDF_ACC_RW);

  mdf_pkg::mdf_coef_t coef_q [`MDF_NBANK][`MDF_TAPS];
  mdf_pkg::mdf_dec_t  dec;

  // one word per coefficient, bank after bank from the base
  function automatic mdf_pkg::mdf_dec_t addr_decode(
    input logic [`MDF_AW-1:0] addr
  );
    mdf_pkg::mdf_dec_t r;
    int unsigned       idx;
    r   = '0;
    idx = 32'(addr) - 32'(`MDF_BASE);
    if (addr >= `MDF_BASE && idx < `MDF_NCOEF) begin
      r.hit  = 1'b1;
      r.bank = `MDF_BKW'(idx / `MDF_TAPS);
      r.tap  = 4'(idx % `MDF_TAPS);
    end
    return r;
  endfunction : addr_decode

  assign dec = addr_decode(mm_req.addr);

  // constant mode never leaves the build-time values
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      coef_q <= INIT;
    end else if (CAN_WR && mm_req.wr && dec.hit) begin
      coef_q[dec.bank][dec.tap] <= mm_req.wdata[`MDF_CW-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
    end else begin
      rvalid_q <= CAN_RD && mm_req.rd;
      if (CAN_RD && mm_req.rd) begin
        rdata_q <= dec.hit ?
          `MDF_DW'(signed'(coef_q[dec.bank][dec.tap])) : '0;
      end
    end
  end

  always_comb begin
    for (int k = 0; k < `MDF_TAPS; k++) begin
      cset[k] = coef_q[bank_sel][k];
    end
  end

endmodule : mdf_coef_store

/* File: hdl/mdf_chan_map.sv */
`timescale 1ns/1ps
`include "mdf_map.svh"

module mdf_chan_map (
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire logic                in_valid,
  input  wire logic [`MDF_MDW-1:0] mode_sel,
  output mdf_pkg::mdf_chan_t       slot_chan
);

  localparam mdf_pkg::mdf_chan_t MAP [`MDF_NMODE][`MDF_NSLOT] = `MDF_CMAP;

  logic [`MDF_SLW-1:0] slot_q;
  logic [`MDF_MDW-1:0] mode_q;

  // a mode change restarts the slot sequence so rows never mix
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      slot_q <= '0;
      mode_q <= '0;
    end else begin
      mode_q <= mode_sel;
      if (mode_sel != mode_q) begin
        slot_q <= in_valid ? `MDF_SLW'(1) : '0;
      end else if (in_valid) begin
        slot_q <= (slot_q == `MDF_SLW'(`MDF_NSLOT - 1)) ?
                  '0 : slot_q + `MDF_SLW'(1);
      end
    end
  end

  // channel mapped to the slot of the current valid sample in the selected row
  always_comb begin
    if (mode_sel != mode_q) begin
      slot_chan = MAP[mode_sel][0];
    end else begin
      slot_chan = MAP[mode_sel][slot_q];
    end
  end

endmodule : mdf_chan_map

/* File: hdl/mdf_top.sv */
`timescale 1ns/1ps
`include "mdf_map.svh"

module mdf_top #(
  parameter int unsigned           DEC    = `MDF_DEC,
  parameter mdf_pkg::mdf_sym_t     SYM    = mdf_pkg::MDF_SYM_EVEN,
  parameter int unsigned           BAND   = `MDF_BAND,
  parameter mdf_pkg::mdf_access_t  ACCESS = mdf_pkg::MDF_ACC_RW,
  parameter logic                  RECONF = 1'b0
) (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire mdf_pkg::mdf_in_beat_t in_beat,
  input  wire logic [`MDF_MDW-1:0]   mode_sel,
  input  wire logic [`MDF_BKW-1:0]   bank_sel,
  input  wire mdf_pkg::mdf_mm_req_t  mm_req,
  output logic [`MDF_DW-1:0]         mm_rdata,
  output logic                       mm_rvalid,
  output mdf_pkg::mdf_out_beat_t     out_beat
);

  // an integer-typed parameter; a fractional rate has no encoding here
  localparam int unsigned DEC_LAST = DEC - 1;
  // a rate below two is not a decimator; a zero-size array stops elaboration
  localparam int unsigned DEC_GUARD = (DEC >= 2) ? 1 : 0;

  mdf_pkg::mdf_win_t   hist_q  [`MDF_NCH];
  logic [`MDF_PHW-1:0] phase_q [`MDF_NCH];
  logic                valid_q;
  mdf_pkg::mdf_chan_t  chan_q;
  mdf_pkg::mdf_acc_t   acc_q;

  mdf_pkg::mdf_chan_t  map_chan;
  mdf_pkg::mdf_chan_t  cur_chan;
  mdf_pkg::mdf_win_t   win_new;
  mdf_pkg::mdf_cset_t  cset;
  logic                accept;
  logic                fire;
  logic                guard_unused [DEC_GUARD];

  assign guard_unused = '{default: 1'b0};

  // zero tap of an Nth-band filter: nonzero offset multiple of N from centre
  function automatic logic tap_live(input int k, input int band);
    int d;
    d = (k > `MDF_CTR) ? (k - `MDF_CTR) : (`MDF_CTR - k);
    return (band < 2) || (d == 0) || ((d % band) != 0);
  endfunction : tap_live

  // full precision dot product; pairs share one multiplier when symmetric
  function automatic mdf_pkg::mdf_acc_t fir_dot(
    input mdf_pkg::mdf_win_t  w,
    input mdf_pkg::mdf_cset_t c
  );
    mdf_pkg::mdf_acc_t      a;
    logic signed [`MDF_IW:0] pre;
    a   = '0;
    pre = '0;
    for (int k = 0; k < `MDF_TAPS; k++) begin
      if (tap_live(k, int'(BAND))) begin
        if (SYM == mdf_pkg::MDF_SYM_NONE) begin
          pre = (`MDF_IW+1)'(w[k]);
          a = a + mdf_pkg::mdf_acc_t'(mdf_pkg::mdf_prod_t'(pre) *
                                      mdf_pkg::mdf_prod_t'(c[k]));
        end else if (k < `MDF_HALF) begin
          if (SYM == mdf_pkg::MDF_SYM_EVEN) begin
            pre = (`MDF_IW+1)'(w[k]) + (`MDF_IW+1)'(w[`MDF_TAPS-1-k]);
          end else begin
            pre = (`MDF_IW+1)'(w[k]) - (`MDF_IW+1)'(w[`MDF_TAPS-1-k]);
          end
          a = a + mdf_pkg::mdf_acc_t'(mdf_pkg::mdf_prod_t'(pre) *
                                      mdf_pkg::mdf_prod_t'(c[k]));
        end else if (k == `MDF_CTR && SYM == mdf_pkg::MDF_SYM_EVEN) begin
          // antisymmetric sets have a zero centre tap
          pre = (`MDF_IW+1)'(w[k]);
          a = a + mdf_pkg::mdf_acc_t'(mdf_pkg::mdf_prod_t'(pre) *
                                      mdf_pkg::mdf_prod_t'(c[k]));
        end
      end
    end
    return a;
  endfunction : fir_dot

  mdf_chan_map u_chan_map (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (in_beat.valid),
    .mode_sel  (mode_sel),
    .slot_chan (map_chan)
  );

  mdf_coef_store #(
    .ACCESS (ACCESS)
  ) u_coef_store (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .mm_req   (mm_req),
    .bank_sel (bank_sel),
    .cset     (cset),
    .rdata_q  (mm_rdata),
    .rvalid_q (mm_rvalid)
  );

  assign accept = in_beat.valid;

  // tag from the stream, or from the map row in reconfigurable builds
  assign cur_chan = RECONF ? map_chan : in_beat.chan;

  // newest sample enters at index 0 of that channel's window
  always_comb begin
    win_new[0] = in_beat.data;
    for (int k = 1; k < `MDF_TAPS; k++) begin
      win_new[k] = hist_q[cur_chan][k-1];
    end
  end

  assign fire = accept &&
                (phase_q[cur_chan] == `MDF_PHW'(DEC_LAST));

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < `MDF_NCH; i++) begin
        hist_q[i] <= '0;
      end
    end else if (accept) begin
      hist_q[cur_chan] <= win_new;
    end
  end

  // per-channel decimation phase; one output for every DEC inputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < `MDF_NCH; i++) begin
        phase_q[i] <= '0;
      end
    end else if (accept) begin
      if (fire) begin
        phase_q[cur_chan] <= '0;
      end else begin
        phase_q[cur_chan] <= phase_q[cur_chan] + `MDF_PHW'(1);
      end
    end
  end

  // products only on kept slots; data holds stale values otherwise
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      acc_q <= '0;
    end else if (fire) begin
      acc_q <= fir_dot(win_new, cset);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      valid_q <= 1'b0;
      chan_q  <= '0;
    end else begin
      valid_q <= fire;
      if (fire) begin
        chan_q <= cur_chan;
      end
    end
  end

  // data may be non-zero with valid low; consumers must gate on valid
  assign out_beat.valid = valid_q;
  assign out_beat.chan  = chan_q;
  assign out_beat.data  = acc_q;

endmodule : mdf_top

/* File: verif/mdf_top_asserts.sv */
`timescale 1ns/1ps
`include "mdf_map.svh"

module mdf_top_asserts #(
  parameter int unsigned          DEC    = `MDF_DEC,
  parameter mdf_pkg::mdf_access_t ACCESS = mdf_pkg::MDF_ACC_RW,
  parameter logic                 RECONF = 1'b0
) (
  input wire logic                   mclk,
  input wire logic                   sys_rst,
  input wire mdf_pkg::mdf_in_beat_t  in_beat,
  input wire logic [`MDF_MDW-1:0]    mode_sel,
  input wire logic [`MDF_BKW-1:0]    bank_sel,
  input wire mdf_pkg::mdf_mm_req_t   mm_req,
  input wire logic [`MDF_DW-1:0]     mm_rdata,
  input wire logic                   mm_rvalid,
  input wire mdf_pkg::mdf_out_beat_t out_beat
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  localparam logic CAN_RD = (ACCESS == mdf_pkg::MDF_ACC_RO) ||
                            (ACCESS == mdf_pkg::MDF_ACC_RW);
  wire logic miss = mm_req.addr < `MDF_BASE ||
                    mm_req.addr > `MDF_BASE + `MDF_NCOEF - 1;
  a_out_cause: assert property (
    out_beat.valid |-> $past(in_beat.valid))
    else $error("output without an accepted sample");
  a_out_chan: assert property (
    !RECONF && out_beat.valid |-> out_beat.chan == $past(in_beat.chan))
    else $error("output channel differs from input tag");
  // with two or more samples per output a channel cannot fire twice in a row
  a_no_twin: assert property (
    DEC > 1 && out_beat.valid && $past(out_beat.valid)
    |-> out_beat.chan != $past(out_beat.chan))
    else $error("one channel fired on consecutive cycles");
  a_data_hold: assert property (
    !out_beat.valid && !$past(sys_rst) |-> $stable(out_beat.data))
    else $error("output data moved while idle");
  a_rd_answer: assert property (
    CAN_RD && mm_req.rd |=> mm_rvalid ##1 (!mm_rvalid || $past(mm_req.rd)))
    else $error("read not answered in one cycle");
  a_rd_silent: assert property (
    !CAN_RD |-> !mm_rvalid)
    else $error("read answer in a build without reads");
  a_rv_cause: assert property (
    mm_rvalid |-> $past(mm_req.rd))
    else $error("read answer without a read");
  a_unmapped_zero: assert property (
    mm_req.rd && miss |=> mm_rdata == '0)
    else $error("unmapped read returned data");
  a_sign_ext: assert property (
    mm_rvalid |-> mm_rdata[31:17] == {15{mm_rdata[17]}})
    else $error("read data not sign extended");
  c_out: cover property (out_beat.valid);
  c_twin: cover property (out_beat.valid ##1 out_beat.valid);
  c_read: cover property (mm_req.rd ##1 mm_rvalid);
endmodule : mdf_top_asserts

bind mdf_top mdf_top_asserts #(.DEC(DEC), .ACCESS(ACCESS), .RECONF(RECONF))
  u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .in_beat(in_beat), .mode_sel(mode_sel),
  .bank_sel(bank_sel), .mm_req(mm_req), .mm_rdata(mm_rdata),
  .mm_rvalid(mm_rvalid), .out_beat(out_beat));

/* File: verif/mdf_sink.sv */
`timescale 1ns/1ps

module mdf_sink (
  input wire logic                   mclk,
  input wire mdf_pkg::mdf_out_beat_t out_beat,
  output logic [15:0]                got_q,
  output mdf_pkg::mdf_acc_t          last_q
);
  initial got_q = '0;
  // idle-cycle data may be stale, so only qualified beats are taken
  always @(posedge mclk) begin
    if (out_beat.valid === 1'b1) begin
      got_q  <= got_q + 16'h0001;
      last_q <= out_beat.data;
    end
  end
endmodule : mdf_sink

/* File: verif/mdf_top_tb.sv */
`timescale 1ns/1ps
`include "mdf_map.svh"

module mdf_top_tb;
  localparam int DEC  = `MDF_DEC;
  localparam int BAND = `MDF_BAND;
  logic                   mclk;
  logic                   sys_rst;
  mdf_pkg::mdf_in_beat_t  in_beat;
  logic [`MDF_MDW-1:0]    mode_sel;
  logic [`MDF_BKW-1:0]    bank_sel;
  mdf_pkg::mdf_mm_req_t   mm_req;
  logic [`MDF_DW-1:0]     mm_rdata;
  logic                   mm_rvalid;
  mdf_pkg::mdf_out_beat_t out_beat;
  logic [15:0]            got_q;
  mdf_pkg::mdf_acc_t      last_q;
  mdf_pkg::mdf_out_beat_t exp_ob;
  mdf_pkg::mdf_acc_t      exp_last;
  logic [31:0]            exp_rd;
  mdf_pkg::mdf_coef_t     coef [2][11];
  mdf_pkg::mdf_coef_t     cinit [2][11];
  mdf_pkg::mdf_chan_t     cmap [2][4];
  mdf_pkg::mdf_out_beat_t exp_ob2;
  mdf_pkg::mdf_out_beat_t out_b2;
  logic [31:0]            rd2;
  logic                   rv2;
  int                     hist2 [4][11];
  int                     ph2 [4];
  int                     slot2;
  int                     mode2;
  int                     hist [4][11];
  int                     ph [4];
  int                     n_exp;
  int                     n_fail;
  int                     n_checks;
  int                     i;
  logic [31:0]            seed;

  mdf_top uut (.mclk(mclk), .sys_rst(sys_rst), .in_beat(in_beat),
    .mode_sel(mode_sel), .bank_sel(bank_sel), .mm_req(mm_req),
    .mm_rdata(mm_rdata), .mm_rvalid(mm_rvalid), .out_beat(out_beat));
  // second build: map-driven tags, coefficients fixed, no host access
  mdf_top #(.ACCESS(mdf_pkg::MDF_ACC_CONST), .RECONF(1'b1)) u_rc (
    .mclk(mclk), .sys_rst(sys_rst), .in_beat(in_beat),
    .mode_sel(mode_sel), .bank_sel(bank_sel), .mm_req(mm_req),
    .mm_rdata(rd2), .mm_rvalid(rv2), .out_beat(out_b2));
  mdf_sink sink (.mclk(mclk), .out_beat(out_beat), .got_q(got_q),
    .last_q(last_q));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // symmetric model: tap t uses coefficient min(t, 10-t), band zeros out
  function automatic longint fir(input int h [11],
                                 input mdf_pkg::mdf_coef_t cs [11]);
    longint a;
    int     j;
    a = 0;
    for (int t = 0; t < 11; t++) begin
      j = (t <= 5) ? t : 10 - t;
      if (j == 5 || (5 - j) % BAND != 0) begin
        a += longint'(h[t]) * cs[j];
      end
    end
    return a;
  endfunction : fir

  task automatic bad(input string what);
    n_fail++;
    $display("ERROR %0t %s", $time, what);
  endtask : bad

  task automatic chk_out(input mdf_pkg::mdf_out_beat_t a,
                         input mdf_pkg::mdf_out_beat_t e);
    n_checks++;
    if (a.valid !== e.valid || (e.valid && a !== e))
      bad("stream output mismatch");
  endtask : chk_out

  task automatic chk_rd(input logic av, input logic [31:0] ad,
                        input logic v, input logic [31:0] d);
    n_checks++;
    if (av !== v || ad !== d)
      bad("coefficient read mismatch");
  endtask : chk_rd

  task automatic chk_sink();
    n_checks++;
    if (got_q !== 16'(n_exp) || last_q !== exp_last)
      bad("downstream count or last value mismatch");
  endtask : chk_sink

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // model what the inputs now on the pins cause, then check at next fall
  task automatic tick();
    mdf_pkg::mdf_coef_t v;
    longint             acc;
    int                 c;
    int                 t;
    int                 off;
    logic               rv;
    rv = 1'b0;
    exp_ob.valid = 1'b0;
    exp_ob2.valid = 1'b0;
    off = int'(mm_req.addr) - int'(`MDF_BASE);
    if (sys_rst) begin
      exp_ob = '0;
      exp_ob2 = '0;
      exp_rd = '0;
      coef = `MDF_COEF_INIT;
      cinit = `MDF_COEF_INIT;
      cmap = `MDF_CMAP;
      hist = '{default: 0};
      hist2 = '{default: 0};
      ph = '{default: 0};
      ph2 = '{default: 0};
      slot2 = 0;
      mode2 = 0;
    end else begin
      // map build: a mode change restarts the slot count at slot 0
      if (int'(mode_sel) != mode2) begin
        slot2 = 0;
      end
      mode2 = int'(mode_sel);
      if (in_beat.valid) begin
        c = int'(cmap[mode_sel][slot2]);
        slot2 = (slot2 + 1) % 4;
        for (t = 10; t > 0; t--) begin
          hist2[c][t] = hist2[c][t-1];
        end
        hist2[c][0] = int'($signed(in_beat.data));
        ph2[c]++;
        if (ph2[c] == DEC) begin
          ph2[c] = 0;
          acc = fir(hist2[c], cinit[bank_sel]);
          exp_ob2 = '{1'b1, 2'(c), acc[38:0]};
        end
      end
      if (in_beat.valid) begin
        c = int'(in_beat.chan);
        for (t = 10; t > 0; t--) begin
          hist[c][t] = hist[c][t-1];
        end
        hist[c][0] = int'($signed(in_beat.data));
        ph[c]++;
        if (ph[c] == DEC) begin
          ph[c] = 0;
          acc = fir(hist[c], coef[bank_sel]);
          exp_ob = '{1'b1, in_beat.chan, acc[38:0]};
          exp_last = acc[38:0];
          n_exp++;
        end
      end
      if (mm_req.rd) begin
        rv = 1'b1;
        v = (off >= 0 && off < 22) ? coef[off / 11][off % 11] : '0;
        exp_rd = int'(v);
      end
      if (mm_req.wr && off >= 0 && off < 22) begin
        coef[off / 11][off % 11] = mm_req.wdata[17:0];
      end
    end
    @(negedge mclk);
    chk_out(out_beat, exp_ob);
    chk_out(out_b2, exp_ob2);
    chk_rd(mm_rvalid, mm_rdata, rv, exp_rd);
    chk_rd(rv2, rd2, 1'b0, 32'h0000_0000);
  endtask : tick

  initial begin
    in_beat = '0;
    mode_sel = '0;
    bank_sel = '0;
    mm_req = '0;
    sys_rst = 1'b1;
    n_exp = 0;
    n_fail = 0;
    n_checks = 0;
    seed = 32'h0000_e396;
    repeat (3) tick();
    sys_rst = 1'b0;
    for (i = 62; i < 88; i++) begin
      mm_req.rd = 1'b1;
      mm_req.addr = 8'(i);
      tick();
    end
    for (i = 0; i < 600; i++) begin
      seed = lfsr(seed);
      in_beat = '{seed[0] | seed[1], seed[3:2], seed[31:16]};
      bank_sel = seed[4];
      mode_sel = seed[5];
      mm_req.wr = seed[10:6] == 5'h00;
      mm_req.rd = seed[11] & seed[12] & !mm_req.wr;
      mm_req.addr = 8'h3f + {3'h0, seed[28:24]};
      mm_req.wdata = {seed[15:0], seed[31:16]};
      sys_rst = i == 300;
      tick();
    end
    in_beat = '0;
    mm_req = '0;
    sys_rst = 1'b0;
    repeat (2) tick();
    chk_sink();
    close_out();
  end

  initial begin
    #100000;
    bad("run did not finish in time");
    close_out();
  end
endmodule : mdf_top_tb
